/* src/smr_pkg.sv */
// package for the registered state machine rom: widths, config carrier, reset values
package smr_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 16;
    localparam int DEPTH = 2048;
    localparam logic [10:0] ADDR_ZERO = 11'h000;
    localparam logic [15:0] DATA_ZERO = 16'h0000;
    localparam logic [15:0] INIT_WORD_DEF = 16'h0000;

    // static configuration; a set bit means registered / feedback / active high, except in init_word, which holds the initialise word itself
    typedef struct packed {
        logic [10:0] addr_reg_en;
        logic [10:0] addr_fb_sel;
        logic [15:0] out_reg_en;
        logic [1:0] cs_reg_en;
        logic cs_act_high;
        logic [1:0] init_reg_en;
        logic [15:0] init_word;
    } smr_cfg_t;

    localparam smr_cfg_t CFG_DEF = '{
        addr_reg_en: 11'h7FF,
        addr_fb_sel: 11'h000,
        out_reg_en: 16'hFFFF,
        cs_reg_en: 2'h3,
        cs_act_high: 1'h1,
        init_reg_en: 2'h3,
        init_word: 16'h0000
    };

    localparam smr_cfg_t CFG_ASYNC = '{
        addr_reg_en: 11'h000,
        addr_fb_sel: 11'h000,
        out_reg_en: 16'h0000,
        cs_reg_en: 2'h0,
        cs_act_high: 1'h1,
        init_reg_en: 2'h0,
        init_word: 16'h0000
    };
endpackage : smr_pkg

/* src/smr_array.sv */
// 2048 x 16 array with combinational read
module smr_array #(
    parameter int AW = smr_pkg::ADDR_W,
    parameter int DW = smr_pkg::DATA_W,
    parameter logic [2**AW*DW-1:0] CONTENTS = '0
) (
    input wire logic [AW-1:0] addr,
    output logic [DW-1:0] data
);
    logic [DW-1:0] mem [2**AW];

    // contents fixed at build time, never written in operation
    always_comb begin
        for (int i = 0; i < 2**AW; i++) begin
            mem[i] = CONTENTS[i*DW +: DW];
        end
    end

    assign data = mem[addr];
endmodule // smr_array

/* src/smr_top.sv */
// registered state machine rom: address muxes, bypassable registers, select and initialise
// Operation
// - a fixed 2048 by 16 array supplies outputs and state bits
// - array outputs feed back as next state, up to 2048 states
// - every word holds output data plus next-state selecting bits
// - address is 11 bits, each from a pin or from feedback
// - each address bit has its own independent pin or feedback selector
// - all input and output registers share one clock
// - each address, select, initialise and output register captures on rising edge or is bypassed; sync and port flops always capture
// - synchronous chip select plus output enable, both synchronised and registered, gate the outputs
// - sync or async initialise forces outputs and state to initialise word
// - all bypassable registers bypassed makes out_word a combinational rom; the ports still come from flip-flops
// - initialise sampled low by the first init stage shows the initialise word on data_out three edges later with all stages registered
// - chip select polarity programmable, passes two bypassable register stages
// - registered address adds one cycle; bypassed address acts same cycle
module smr_top #(
    parameter smr_pkg::smr_cfg_t CFG = smr_pkg::CFG_DEF,
    parameter logic [2**smr_pkg::ADDR_W*smr_pkg::DATA_W-1:0] CONTENTS = '0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [10:0] addr_pin,
    input wire logic chip_sel,
    input wire logic init_n,
    input wire logic out_en_n,
    output logic [15:0] data_out,
    output logic [15:0] data_oe,
    output logic [15:0] state_word
);
    localparam int AW = smr_pkg::ADDR_W;
    localparam int DW = smr_pkg::DATA_W;

    // pin inputs: three-stage synchronisers, change accepted once stages 2 and 3 agree
    logic [AW+2:0] sync1_ff, sync2_ff, sync3_ff, clean_ff;
    logic [AW+2:0] nxt_clean;
    logic [AW+2:0] pins_raw;
    assign pins_raw = {out_en_n, init_n, chip_sel, addr_pin};
    // idle levels: a zero in the init stages would fake an initialise on the first edge after reset
    localparam logic [AW+2:0] PIN_IDLE = {1'h1, 1'h1, ~CFG.cs_act_high, smr_pkg::ADDR_ZERO};

    always_comb begin
        for (int i = 0; i < AW + 3; i++) begin
            nxt_clean[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : clean_ff[i];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_ff <= PIN_IDLE;
            sync2_ff <= PIN_IDLE;
            sync3_ff <= PIN_IDLE;
            clean_ff <= PIN_IDLE;
        end else begin
            sync1_ff <= pins_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            clean_ff <= nxt_clean;
        end
    end

    logic [AW-1:0] addr_in;
    logic cs_in, init_in_n, oe_in_n;
    assign addr_in = clean_ff[AW-1:0];
    assign cs_in = clean_ff[AW];
    assign init_in_n = clean_ff[AW+1];
    assign oe_in_n = clean_ff[AW+2];

    // registered word: output registers hold both data and state feedback
    logic [DW-1:0] out_ff, nxt_out;
    logic [DW-1:0] word;
    logic [DW-1:0] out_word;
    logic [AW-1:0] addr_ff, nxt_addr;
    logic [AW-1:0] addr_sel, addr_eff;
    logic [1:0] cs_ff, nxt_cs;
    logic [1:0] init_ff, nxt_init;
    logic cs_eff, init_eff, cs_act;

    function automatic logic stage_pick(input logic reg_en, input logic q, input logic d);
        return reg_en ? q : d;
    endfunction

    // feedback comes from the output stage, upper bits above the dedicated outputs
    always_comb begin
        for (int i = 0; i < AW; i++) begin
            addr_sel[i] = CFG.addr_fb_sel[i] ? out_word[DW-AW+i] : addr_in[i];
        end
    end

    always_comb begin
        for (int i = 0; i < AW; i++) begin
            addr_eff[i] = stage_pick(CFG.addr_reg_en[i], addr_ff[i], addr_sel[i]);
        end
    end

    smr_array #(
        .AW(AW),
        .DW(DW),
        .CONTENTS(CONTENTS)
    ) u_array (
        .addr(addr_eff),
        .data(word)
    );

    // select polarity applied before the two stages; each stage bypassable
    assign cs_act = CFG.cs_act_high ? cs_in : ~cs_in;
    logic cs_s1;
    assign cs_s1 = stage_pick(CFG.cs_reg_en[0], cs_ff[0], cs_act);
    assign cs_eff = stage_pick(CFG.cs_reg_en[1], cs_ff[1], cs_s1);

    logic init_s1;
    assign init_s1 = stage_pick(CFG.init_reg_en[0], init_ff[0], ~init_in_n);
    assign init_eff = stage_pick(CFG.init_reg_en[1], init_ff[1], init_s1);

    always_comb begin
        nxt_addr = addr_sel;
        nxt_cs = {cs_s1, cs_act};
        nxt_init = {init_s1, ~init_in_n};
        // initialise wins over array data, reaching state and outputs alike
        nxt_out = init_eff ? CFG.init_word : word;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            addr_ff <= smr_pkg::ADDR_ZERO;
            cs_ff <= 2'h0;
            init_ff <= 2'h0;
            out_ff <= smr_pkg::DATA_ZERO;
        end else begin
            addr_ff <= nxt_addr;
            cs_ff <= nxt_cs;
            init_ff <= nxt_init;
            out_ff <= nxt_out;
        end
    end

    // bypassed output bits are mealy style, straight from the array
    always_comb begin
        for (int i = 0; i < DW; i++) begin
            out_word[i] = stage_pick(CFG.out_reg_en[i], out_ff[i], nxt_out[i]);
        end
    end

    // ports come from flip-flops, so the pin view lags out_word by one cycle;
    // the trade keeps the boundary glitch free even in bypass mode
    logic [DW-1:0] dout_ff, nxt_dout, oe_ff, nxt_oe, st_ff, nxt_st;
    always_comb begin
        nxt_dout = out_word;
        nxt_st = out_word;
        nxt_oe = (cs_eff && !oe_in_n) ? '1 : '0;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dout_ff <= smr_pkg::DATA_ZERO;
            oe_ff <= smr_pkg::DATA_ZERO;
            st_ff <= smr_pkg::DATA_ZERO;
        end else begin
            dout_ff <= nxt_dout;
            oe_ff <= nxt_oe;
            st_ff <= nxt_st;
        end
    end

    assign data_out = dout_ff;
    assign data_oe = oe_ff;
    assign state_word = st_ff;

    // configuration is elaboration-time only, no port can alter it

    property init_word_p;
        @(posedge ref_clk) disable iff (rst)
        (init_eff && CFG.out_reg_en == '1) |=> ##1 (data_out == CFG.init_word);
    endproperty
    init_forces_word_a: assert property (init_word_p)
        else $error("initialise word not shown");

    oe_gated_a: assert property (@(posedge ref_clk) disable iff (rst)
        (oe_in_n || !cs_eff) |=> (data_oe == '0))
        else $error("outputs enabled while deselected");

    oe_on_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!oe_in_n && cs_eff) |=> (data_oe == '1))
        else $error("outputs not enabled while selected");

    addr_latency_a: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> (addr_ff == $past(addr_sel)))
        else $error("address register missed a cycle");

    state_tracks_a: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> (state_word == $past(out_word)))
        else $error("state word lags wrong");

    data_state_same_a: assert property (@(posedge ref_clk) disable iff (rst)
        data_out == state_word)
        else $error("data and state disagree");

    out_reg_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!init_eff) |=> (out_ff == $past(word)))
        else $error("output register not loaded from array");

    cs_two_stage_a: assert property (@(posedge ref_clk) disable iff (rst)
        CFG.cs_reg_en[0] |=> ##1 (cs_ff[1] == $past(cs_act, 2)))
        else $error("select stages wrong depth");

    sync_first_a: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> (sync1_ff == $past(pins_raw)))
        else $error("first sync stage missed a pin value");

    sync_chain_a: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> (sync2_ff == $past(sync1_ff) && sync3_ff == $past(sync2_ff)))
        else $error("sync chain did not shift");

    clean_accept_a: assert property (@(posedge ref_clk) disable iff (rst)
        (sync2_ff == sync3_ff) |=> (clean_ff == $past(sync3_ff)))
        else $error("agreed pin value not accepted");

    clean_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        (sync2_ff[AW+1] != sync3_ff[AW+1]) |=> (clean_ff[AW+1] == $past(clean_ff[AW+1])))
        else $error("initialise pin taken before stages agreed");

    sync_reset_a: assert property (@(posedge ref_clk)
        rst |=> (clean_ff == PIN_IDLE && sync3_ff == PIN_IDLE))
        else $error("pin stages not idle after reset");

    fb_select_a: assert property (@(posedge ref_clk) disable iff (rst)
        addr_sel == ((out_word[DW-1:DW-AW] & CFG.addr_fb_sel) | (addr_in & ~CFG.addr_fb_sel)))
        else $error("address selector picked wrong source");

    addr_bypass_a: assert property (@(posedge ref_clk) disable iff (rst)
        addr_eff == ((addr_ff & CFG.addr_reg_en) | (addr_sel & ~CFG.addr_reg_en)))
        else $error("address bypass choice wrong");

    array_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        word == CONTENTS[addr_eff*DW +: DW])
        else $error("array word does not match contents");

    out_bypass_a: assert property (@(posedge ref_clk) disable iff (rst)
        out_word == ((out_ff & CFG.out_reg_en) | (nxt_out & ~CFG.out_reg_en)))
        else $error("output bypass choice wrong");

    cs_stage_one_a: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> (cs_ff[0] == $past(cs_act)))
        else $error("first select stage missed");

    init_stage_one_a: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> (init_ff[0] == $past(!init_in_n)))
        else $error("first initialise stage missed");

    init_stage_two_a: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> (init_ff[1] == $past(init_s1)))
        else $error("second initialise stage missed");

    init_out_a: assert property (@(posedge ref_clk) disable iff (rst)
        init_eff |=> (out_ff == CFG.init_word))
        else $error("initialise word not loaded");

    dout_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> (data_out == $past(out_word)))
        else $error("data pins lag wrong");

    async_rom_a: assert property (@(posedge ref_clk) disable iff (rst)
        (CFG.out_reg_en == '0 && CFG.addr_reg_en == '0 && CFG.addr_fb_sel == '0 && !init_eff)
        |-> (out_word == CONTENTS[addr_in*DW +: DW]))
        else $error("bypassed rom path not combinational");

    oe_whole_a: assert property (@(posedge ref_clk) disable iff (rst)
        (data_oe == '0 || data_oe == '1))
        else $error("output enable bits split");

    reset_clear_a: assert property (@(posedge ref_clk)
        rst |=> (data_out == '0 && data_oe == '0 && state_word == '0))
        else $error("outputs not cleared by reset");

    // covers: the main scenarios that the bench should reach
    init_cov_c: cover property (@(posedge ref_clk) disable iff (rst) init_eff ##2 !init_eff);
    oe_off_c: cover property (@(posedge ref_clk) disable iff (rst) data_oe == '1 ##1 data_oe == '0);
    fb_run_c: cover property (@(posedge ref_clk) disable iff (rst) !init_eff [*4]);
    deselect_c: cover property (@(posedge ref_clk) disable iff (rst) cs_eff ##1 !cs_eff);
endmodule // smr_top

/* tb/smr_sys_model.sv */
// system-side partner: drives the block's pins from the bench's commands
module smr_sys_model (
    input wire logic ref_clk,
    input wire logic [10:0] cmd_addr,
    input wire logic cmd_cs,
    input wire logic cmd_init_n,
    input wire logic cmd_oe_n,
    output logic [10:0] addr_pin,
    output logic chip_sel,
    output logic init_n,
    output logic out_en_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {addr_pin, chip_sel, init_n, out_en_n} = {11'h000, 1'h1, 1'h1, 1'h1};
    end
    // pins move only at the falling edge, well clear of the sampling edge
    always @(negedge ref_clk) begin
        {addr_pin, chip_sel, init_n, out_en_n} <= {cmd_addr, cmd_cs, cmd_init_n, cmd_oe_n};
    end
endmodule // smr_sys_model

/* tb/smr_top_tb.sv */
// self-checking bench for the registered state machine rom
module smr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // bit 0 of the address fed back from state bit 5; select active low
    localparam smr_pkg::smr_cfg_t CFG = '{addr_reg_en: 11'h7FF, addr_fb_sel: 11'h001, out_reg_en: 16'hFFFF,
        cs_reg_en: 2'h3, cs_act_high: 1'h0, init_reg_en: 2'h3, init_word: 16'h0035};
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic [10:0] cmd_addr = 11'h000;
    logic cmd_cs = 1'h1;
    logic cmd_init_n = 1'h1;
    logic cmd_oe_n = 1'h1;
    logic [10:0] addr_pin;
    logic chip_sel, init_n, out_en_n;
    logic [15:0] data_out, data_oe, state_word, comb_out;
    logic [63:0] exp_q[$];
    int bad_count = 0;
    int checks = 0;
    int seed = 46210;
    event got;

    // bit 5 of word i echoes address bit 0, so the feedback loop holds still
    function automatic logic [15:0] word_of(logic [10:0] a);
        return {a, a[4:0] ^ 5'h15};
    endfunction
    function automatic logic [32767:0] fill();
        logic [32767:0] m;
        for (int i = 0; i < 2048; i++) m[i*16+:16] = word_of(11'(i));
        return m;
    endfunction
    localparam logic [32767:0] MEM = fill();

    smr_sys_model sys_u (.ref_clk(ref_clk), .cmd_addr(cmd_addr), .cmd_cs(cmd_cs), .cmd_init_n(cmd_init_n),
        .cmd_oe_n(cmd_oe_n), .addr_pin(addr_pin), .chip_sel(chip_sel), .init_n(init_n), .out_en_n(out_en_n));
    smr_top #(.CFG(CFG), .CONTENTS(MEM)) dut_u (.ref_clk(ref_clk), .rst(rst), .addr_pin(addr_pin),
        .chip_sel(chip_sel), .init_n(init_n), .out_en_n(out_en_n), .data_out(data_out), .data_oe(data_oe),
        .state_word(state_word));
    smr_top #(.CFG(smr_pkg::CFG_ASYNC), .CONTENTS(MEM)) dut_c_u (.ref_clk(ref_clk), .rst(rst),
        .addr_pin(addr_pin), .chip_sel(chip_sel), .init_n(init_n), .out_en_n(out_en_n), .data_out(comb_out),
        .data_oe(), .state_word());

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmp_res(logic [63:0] got_v, logic [63:0] e);
        checks++;
        if (got_v !== e) begin
            bad_count++;
            $display("Error at %0t: outputs %h expected %h", $time, got_v, e);
        end
    endtask

    // latency through synchronisers and stages is well under 16 edges; steady value is judged
    task automatic step(logic [10:0] a, logic cs, logic ini, logic oe_n, logic [63:0] e);
        {cmd_addr, cmd_cs, cmd_init_n, cmd_oe_n} = {a, cs, ini, oe_n};
        repeat (16) @(posedge ref_clk);
        exp_q.push_back(e);
        @(negedge ref_clk);
        -> got;
        $display("test done at %0t", $time);
    endtask

    always begin
        @(got);
        cmp_res({data_out, data_oe, state_word, comb_out}, exp_q.pop_front());
    end

    initial begin
        #50000;
        bad_count++;
        give_verdict();
    end

    initial begin
        logic [10:0] a;
        logic fb;
        logic [15:0] w;
        repeat (20) @(negedge ref_clk);
        rst = 1'h0;
        step(11'h2AA, 1'h0, 1'h0, 1'h0, {16'h0035, 16'hFFFF, 16'h0035, 16'h0000});
        fb = 1'h1;
        for (int n = 0; n < 12; n++) begin
            a = (n == 0) ? 11'h7FF : (n == 1) ? 11'h000 : 11'($random(seed));
            if (n == 7) begin
                rst = 1'h1;
                repeat (4) @(negedge ref_clk);
                exp_q.push_back(64'h0);
                -> got;
                @(negedge ref_clk);
                rst = 1'h0;
                fb = 1'h0;
            end
            w = word_of({a[10:1], fb});
            step(a, n == 3, 1'h1, n == 5, {w, (n == 3 || n == 5) ? 16'h0000 : 16'hFFFF, w, word_of(a)});
        end
        // let the checker take the last note before the verdict
        @(posedge ref_clk);
        give_verdict();
    end
endmodule // smr_top_tb
